// >>> core/rdm_mode_ctrl.sv
// Redriver mode, routing, equalization and link state controller
// How it works
// - Lowest interface strap level selects pin mode
// - Enable low powers down, no routing
// - Enable high runs; orientation picks flipped routing
// - Lane one unflipped, lane two flipped routing
// - Power-up defaults to SuperSpeed without pin action
// - Periodic signaling present disables equalization
// - Otherwise equalize from straps or registers
// - Straps latched once at reset release
// - Strap pulls released after hold time
// - Each strap resolves to four levels
// - Strap pairs give sixteen gains per path
// - Periodic receiver detect; termination once found
// - Track U0 to U3 from line conditions
// - Other interface levels select register mode
// - Register code 00 off, 01 on
// - Test, enable, orientation pins are debounced
// - Disconnect goes to U0 on both terminations
`timescale 1ns/1ns
module rdm_mode_ctrl #(
  parameter int unsigned DEBOUNCE_CYCLES = rdm_pkg::PIN_DEBOUNCE_CYCLES,
  parameter int unsigned RXDET_CYCLES = rdm_pkg::RXDET_INTERVAL_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic factoryTestPin,
  input wire logic superspeedEnablePin,
  input wire logic orientationPin,
  input wire rdm_pkg::rdm_straps_s straps,
  input wire rdm_pkg::rdm_phy_s phy,
  output logic strapPullEn,
  output rdm_pkg::rdm_route_e routeSel,
  output logic powerDown,
  output logic rxTermEn,
  output logic rxDetectReq,
  output logic eqEnable,
  output logic [3:0] downstreamEq,
  output logic [3:0] upstreamEq,
  output rdm_pkg::rdm_link_e linkState
);
  logic [2:0] pinRaw;
  logic [2:0] pinDb;
  logic strapValid;
  logic [1:0] ifSelCode;
  logic [3:0] dnGainStrap;
  logic [3:0] upGainStrap;
  logic pullEn;
  logic regMode;
  logic enablePrev;
  logic defaultOn;
  logic active;
  logic flip;
  logic [1:0] controlSelect;
  logic orientationSelect;
  logic [3:0] lane1GainSelect;
  logic [3:0] lane2GainSelect;
  logic [3:0] hostSideGainSelect;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic writeNow;
  logic [31:0] statusWord;
  logic [rdm_pkg::CNT_W-1:0] rxdetCnt;
  logic [rdm_pkg::HOLD_W-1:0] idleCnt;
  logic bothTerm;
  logic detectPhase;
  rdm_pkg::rdm_link_e next_linkState;

  assign pinRaw = {factoryTestPin, superspeedEnablePin, orientationPin};

  // Pin debouncers
  for (genvar i = 0; i < 3; i++) begin : g_db
    rdm_debounce #(
      .COUNT(DEBOUNCE_CYCLES)
    ) u_db (
      .clk(clk),
      .resetn(resetn),
      .din(pinRaw[i]),
      .dout(pinDb[i])
    );
  end

  rdm_strap_latch u_straps (
    .clk(clk),
    .resetn(resetn),
    .straps(straps),
    .valid(strapValid),
    .ifSel(ifSelCode),
    .dnGain(dnGainStrap),
    .upGain(upGainStrap),
    .pullEn(pullEn)
  );

  // Mode selection from the latched interface strap
  assign regMode = strapValid &&
    ifSelCode != rdm_pkg::LVL_TIED_LOW;

  // Power-up default held until the enable pin falls
  always_ff @(posedge clk) begin
    if (!resetn) begin
      enablePrev <= 1'b0;
      defaultOn <= 1'b1;
    end else begin
      enablePrev <= pinDb[1];
      if (enablePrev && !pinDb[1]) begin
        defaultOn <= 1'b0;
      end
    end
  end

  // Operating configuration
  always_comb begin
    if (regMode) begin
      active = controlSelect == rdm_pkg::CTL_SUPERSPEED;
      flip = orientationSelect;
    end else begin
      active = pinDb[1] || defaultOn;
      flip = pinDb[0];
    end
  end

  // Lane multiplexer map
  always_ff @(posedge clk) begin
    if (!resetn) begin
      routeSel <= rdm_pkg::RDM_ROUTE_NONE;
      powerDown <= 1'b1;
    end else begin
      powerDown <= !active;
      if (!active) begin
        routeSel <= rdm_pkg::RDM_ROUTE_NONE;
      end else if (flip) begin
        routeSel <= rdm_pkg::RDM_ROUTE_LANE2;
      end else begin
        routeSel <= rdm_pkg::RDM_ROUTE_LANE1;
      end
    end
  end

  // Equalization source and suppression
  always_ff @(posedge clk) begin
    if (!resetn) begin
      eqEnable <= 1'b0;
      downstreamEq <= 4'h0;
      upstreamEq <= 4'h0;
      strapPullEn <= 1'b1;
    end else begin
      eqEnable <= active && !phy.lfps;
      strapPullEn <= pullEn;
      if (regMode) begin
        downstreamEq <= flip ? lane2GainSelect : lane1GainSelect;
        upstreamEq <= hostSideGainSelect;
      end else begin
        downstreamEq <= dnGainStrap;
        upstreamEq <= upGainStrap;
      end
    end
  end

  // Link power state tracking
  assign bothTerm = phy.farTermUp && phy.farTermDn;
  assign detectPhase = linkState == rdm_pkg::RDM_DISC ||
    linkState == rdm_pkg::RDM_U23;

  always_comb begin
    next_linkState = linkState;
    unique case (linkState)
      rdm_pkg::RDM_DISC: begin
        if (bothTerm) begin
          next_linkState = rdm_pkg::RDM_U0;
        end
      end
      rdm_pkg::RDM_U0: begin
        if (phy.elecIdle) begin
          next_linkState = rdm_pkg::RDM_U1;
        end
      end
      rdm_pkg::RDM_U1: begin
        if (!phy.elecIdle || phy.lfps) begin
          next_linkState = rdm_pkg::RDM_U0;
        end else if (idleCnt ==
                     rdm_pkg::HOLD_W'(rdm_pkg::U1_IDLE_CYCLES - 1)) begin
          next_linkState = rdm_pkg::RDM_U23;
        end
      end
      rdm_pkg::RDM_U23: begin
        if (!bothTerm) begin
          next_linkState = rdm_pkg::RDM_DISC;
        end else if (phy.lfps) begin
          next_linkState = rdm_pkg::RDM_U0;
        end
      end
    endcase
    if (!active) begin
      next_linkState = rdm_pkg::RDM_DISC;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      linkState <= rdm_pkg::RDM_DISC;
      rxTermEn <= 1'b0;
    end else begin
      linkState <= next_linkState;
      rxTermEn <= next_linkState != rdm_pkg::RDM_DISC;
    end
  end

  // Idle dwell count in U1
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idleCnt <= '0;
    end else if (linkState == rdm_pkg::RDM_U1 && next_linkState ==
                 rdm_pkg::RDM_U1) begin
      idleCnt <= idleCnt + 1'b1;
    end else begin
      idleCnt <= '0;
    end
  end

  // Periodic far-end receiver detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxdetCnt <= '0;
      rxDetectReq <= 1'b0;
    end else if (!detectPhase || !active) begin
      rxdetCnt <= '0;
      rxDetectReq <= 1'b0;
    end else if (rxdetCnt == rdm_pkg::CNT_W'(RXDET_CYCLES - 1)) begin
      rxdetCnt <= '0;
      rxDetectReq <= 1'b1;
    end else begin
      rxdetCnt <= rxdetCnt + 1'b1;
      rxDetectReq <= 1'b0;
    end
  end

  // Bus write channels
  assign writeNow = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rdm_pkg::RESP_OKAY;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (writeNow) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= rdm_pkg::regMapped(awAddr) ?
          rdm_pkg::RESP_OKAY : rdm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      controlSelect <= rdm_pkg::CTRL_SEL_RESET;
      orientationSelect <= rdm_pkg::CTRL_FLIP_RESET;
      lane1GainSelect <= rdm_pkg::GAIN_RESET;
      lane2GainSelect <= rdm_pkg::GAIN_RESET;
      hostSideGainSelect <= rdm_pkg::GAIN_RESET;
    end else if (writeNow && wStrb[0]) begin
      unique case (awAddr)
        rdm_pkg::CTRL_OFFSET: begin
          controlSelect <= wData[rdm_pkg::CTRL_SEL_LSB +: 2];
          orientationSelect <= wData[rdm_pkg::CTRL_FLIP_BIT];
        end
        rdm_pkg::LANE1_GAIN_OFFSET: lane1GainSelect <= wData[3:0];
        rdm_pkg::LANE2_GAIN_OFFSET: lane2GainSelect <= wData[3:0];
        rdm_pkg::HOST_GAIN_OFFSET: hostSideGainSelect <= wData[3:0];
        default: ;
      endcase
    end
  end

  // Status view
  assign statusWord = {16'h0000, upstreamEq, downstreamEq, strapPullEn,
    !regMode && pinDb[2], eqEnable, regMode, routeSel,
    linkState};

  // Bus read channel
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rdm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rdm_pkg::regMapped(s_axi_araddr) ?
        rdm_pkg::RESP_OKAY : rdm_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        rdm_pkg::CTRL_OFFSET:
          s_axi_rdata <= {29'h0, orientationSelect, controlSelect};
        rdm_pkg::LANE1_GAIN_OFFSET: s_axi_rdata <= {28'h0, lane1GainSelect};
        rdm_pkg::LANE2_GAIN_OFFSET: s_axi_rdata <= {28'h0, lane2GainSelect};
        rdm_pkg::HOST_GAIN_OFFSET:
          s_axi_rdata <= {28'h0, hostSideGainSelect};
        rdm_pkg::STATUS_OFFSET: s_axi_rdata <= statusWord;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // rdm_mode_ctrl

// >>> core/rdm_pkg.sv
// Shared constants, types and decoders for the redriver mode controller
package rdm_pkg;
  // Timebase
  localparam int CLK_PERIOD_NS = 8;
  localparam int STRAP_HOLD_TIME_NS = 10000;
  localparam int STRAP_HOLD_CYCLES =
    (STRAP_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_DEBOUNCE_MS = 16;
  localparam int PIN_DEBOUNCE_CYCLES =
    (PIN_DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int RXDET_INTERVAL_MS = 12;
  localparam int RXDET_INTERVAL_CYCLES =
    (RXDET_INTERVAL_MS * 1000000) / CLK_PERIOD_NS;
  localparam int U1_IDLE_TIME_NS = 10000;
  localparam int U1_IDLE_CYCLES = U1_IDLE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 21;
  localparam int HOLD_W = 11;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] LANE1_GAIN_OFFSET = 8'h04;
  localparam logic [7:0] LANE2_GAIN_OFFSET = 8'h08;
  localparam logic [7:0] HOST_GAIN_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  // Control register fields and reset values
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_FLIP_BIT = 2;
  localparam logic [1:0] CTL_POWER_DOWN = 2'h0;
  localparam logic [1:0] CTL_SUPERSPEED = 2'h1;
  localparam logic [1:0] CTRL_SEL_RESET = 2'h1;
  localparam logic CTRL_FLIP_RESET = 1'b0;
  localparam logic [3:0] GAIN_RESET = 4'h0;

  // Strap level codes
  localparam logic [1:0] LVL_TIED_LOW = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RDM_DISC = 2'b00,
    RDM_U0 = 2'b01,
    RDM_U1 = 2'b10,
    RDM_U23 = 2'b11
  } rdm_link_e;

  typedef enum logic [1:0] {
    RDM_ROUTE_NONE = 2'b00,
    RDM_ROUTE_LANE1 = 2'b01,
    RDM_ROUTE_LANE2 = 2'b10
  } rdm_route_e;

  // Four-level strap comparator outputs, thermometer coded
  typedef struct packed {
    logic [2:0] ifSel;
    logic [2:0] dnGainHi;
    logic [2:0] dnGainLo;
    logic [2:0] upGainHi;
    logic [2:0] upGainLo;
  } rdm_straps_s;

  // Analog front-end observations
  typedef struct packed {
    logic farTermUp;
    logic farTermDn;
    logic elecIdle;
    logic lfps;
  } rdm_phy_s;

  // Thermometer to two-bit level code
  function automatic logic [1:0] levelCode(input logic [2:0] thermo);
    logic [1:0] sum;
    sum = {1'b0, thermo[0]} + {1'b0, thermo[1]} + {1'b0, thermo[2]};
    return sum;
  endfunction

  function automatic logic regMapped(input logic [7:0] addr);
    return addr == CTRL_OFFSET || addr == LANE1_GAIN_OFFSET ||
      addr == LANE2_GAIN_OFFSET || addr == HOST_GAIN_OFFSET ||
      addr == STATUS_OFFSET;
  endfunction
endpackage

// >>> core/rdm_debounce.sv
// Level debouncer for one control pin
`timescale 1ns/1ns
module rdm_debounce #(
  parameter int unsigned COUNT = rdm_pkg::PIN_DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic [rdm_pkg::CNT_W-1:0] stableCnt;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stableCnt <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      stableCnt <= '0;
    end else if (stableCnt == rdm_pkg::CNT_W'(COUNT - 1)) begin
      stableCnt <= '0;
      dout <= din;
    end else begin
      stableCnt <= stableCnt + 1'b1;
    end
  end
endmodule // rdm_debounce

// >>> core/rdm_strap_latch.sv
// Four-level strap capture and pull resistor release
`timescale 1ns/1ns
module rdm_strap_latch (
  input wire logic clk,
  input wire logic resetn,
  input wire rdm_pkg::rdm_straps_s straps,
  output logic valid,
  output logic [1:0] ifSel,
  output logic [3:0] dnGain,
  output logic [3:0] upGain,
  output logic pullEn
);
  logic [rdm_pkg::HOLD_W-1:0] holdCnt;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      valid <= 1'b0;
      ifSel <= 2'h0;
      dnGain <= 4'h0;
      upGain <= 4'h0;
    end else if (!valid) begin
      valid <= 1'b1;
      ifSel <= rdm_pkg::levelCode(straps.ifSel);
      dnGain <= {rdm_pkg::levelCode(straps.dnGainHi),
                 rdm_pkg::levelCode(straps.dnGainLo)};
      upGain <= {rdm_pkg::levelCode(straps.upGainHi),
                 rdm_pkg::levelCode(straps.upGainLo)};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      holdCnt <= '0;
      pullEn <= 1'b1;
    end else if (valid && pullEn) begin
      if (holdCnt == rdm_pkg::HOLD_W'(rdm_pkg::STRAP_HOLD_CYCLES - 1)) begin
        pullEn <= 1'b0;
      end else begin
        holdCnt <= holdCnt + 1'b1;
      end
    end
  end
endmodule // rdm_strap_latch

// >>> verification/rdm_checker.sv
// Port assertions for the redriver mode controller
`timescale 1ns/1ns
module rdm_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire rdm_pkg::rdm_phy_s phy,
  input wire logic strapPullEn,
  input wire rdm_pkg::rdm_route_e routeSel,
  input wire logic powerDown,
  input wire logic rxTermEn,
  input wire logic rxDetectReq,
  input wire logic eqEnable,
  input wire rdm_pkg::rdm_link_e linkState
);
  logic [10:0] upCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since reset release, saturating
  always_ff @(posedge clk) begin
    if (!resetn) begin
      upCnt <= 11'h0;
    end else if (upCnt != 11'h7ff) begin
      upCnt <= upCnt + 11'h1;
    end
  end
  chk_off_noroute: assert property (
    powerDown |-> routeSel == rdm_pkg::RDM_ROUTE_NONE)
    else $error("Route while powered down");
  chk_on_route: assert property (
    !powerDown |-> routeSel != rdm_pkg::RDM_ROUTE_NONE)
    else $error("No route while on");
  chk_lfps_noeq: assert property (phy.lfps |=> !eqEnable)
    else $error("Equalizer on during periodic signaling");
  chk_eq_resume: assert property (
    !phy.lfps && !powerDown ##1 !powerDown |-> eqEnable)
    else $error("Equalizer off without periodic signaling");
  chk_term_link: assert property (
    rxTermEn == (linkState != rdm_pkg::RDM_DISC))
    else $error("Termination does not follow link state");
  chk_disc_up: assert property (
    linkState == rdm_pkg::RDM_DISC && phy.farTermUp && phy.farTermDn
    && !powerDown ##1 !powerDown |-> linkState == rdm_pkg::RDM_U0)
    else $error("No move to U0 on both terminations");
  chk_idle_low: assert property (
    linkState == rdm_pkg::RDM_U0 && phy.elecIdle && !powerDown
    ##1 !powerDown |-> linkState == rdm_pkg::RDM_U1)
    else $error("No move to U1 on idle");
  chk_det_pulse: assert property (rxDetectReq |=> !rxDetectReq)
    else $error("Detect request longer than one cycle");
  chk_pull_hold: assert property (
    !strapPullEn |-> upCnt >= 11'd1249)
    else $error("Strap pulls released early");
  chk_pull_drop: assert property (
    upCnt >= 11'd1260 |-> !strapPullEn)
    else $error("Strap pulls never released");
  cover property (linkState == rdm_pkg::RDM_U1);
  cover property (rxDetectReq);
  cover property (linkState == rdm_pkg::RDM_U23);
  cover property (routeSel == rdm_pkg::RDM_ROUTE_LANE2);
endmodule // rdm_checker

bind rdm_mode_ctrl rdm_checker u_chk (
  .clk, .resetn, .phy, .strapPullEn, .routeSel, .powerDown,
  .rxTermEn, .rxDetectReq, .eqEnable, .linkState
);

// >>> verification/rdm_pd_model.sv
// Power-delivery controller model driving the control pins
`timescale 1ns/1ns
module rdm_pd_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic reqOn,
  input wire logic reqFlip,
  output logic testPin,
  output logic enPin,
  output logic flipPin
);
  logic enDly, flipDly;
  assign testPin = 1'b0;
  always_ff @(posedge clk) begin
    enDly <= reqOn;
    flipDly <= reqFlip;
  end
  // Pins follow requests one cycle later, or two cycles later when slow
  always_ff @(posedge clk) begin
    enPin <= slow ? enDly : reqOn;
    flipPin <= slow ? flipDly : reqFlip;
  end
endmodule // rdm_pd_model

// >>> verification/rdm_mode_ctrl_test.sv
// Self-checking bench for the redriver mode controller
`timescale 1ns/1ns
module rdm_mode_ctrl_test;
  localparam int DB = 8;
  localparam int RXD = 20;
  logic clk = 1'b0, resetn = 1'b0, slow = 1'b0;
  logic reqOn = 1'b0, reqFlip = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, downstreamEq, upstreamEq;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, strapPullEn, powerDown, rxTermEn, rxDetectReq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic eqEnable, factoryTestPin, superspeedEnablePin, orientationPin;
  rdm_pkg::rdm_straps_s straps = '0;
  rdm_pkg::rdm_phy_s phy = '0;
  rdm_pkg::rdm_route_e routeSel;
  rdm_pkg::rdm_link_e linkState;
  logic [33:0] expQ[$];
  logic [1:0] g[4];
  logic [31:0] seed = 32'd18460;
  int n_fail = 0, checks_done = 0;
  always #4 clk = ~clk;

  rdm_pd_model pd (.clk, .slow, .reqOn, .reqFlip, .testPin(factoryTestPin),
    .enPin(superspeedEnablePin), .flipPin(orientationPin));
  rdm_mode_ctrl #(.DEBOUNCE_CYCLES(DB), .RXDET_CYCLES(RXD)) dut (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .factoryTestPin, .superspeedEnablePin,
    .orientationPin, .straps, .phy, .strapPullEn, .routeSel, .powerDown,
    .rxTermEn, .rxDetectReq, .eqEnable, .downstreamEq, .upstreamEq,
    .linkState);

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [2:0] th(input logic [1:0] l);
    return 3'b111 >> (2'd3 - l);
  endfunction
  task test_done();
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task hang();
    n_fail++;
    $display("Error %0t: bus wait timed out", $time);
    test_done();
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: level %h want %h", $time, got, exp);
    end
  endtask
  task cmpBus(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: bus %h want %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    expQ.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (k == 40) hang();
  endtask
  task axr(input logic [7:0] a, input logic [33:0] e);
    int k;
    expQ.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (k == 40) hang();
  endtask
  task rst(input logic [1:0] ifl);
    int i;
    for (i = 0; i < 4; i++) g[i] = 2'(xs());
    straps <= {th(ifl), th(g[0]), th(g[1]), th(g[2]), th(g[3])};
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(4);
    cmp(strapPullEn, 1'b1);
  endtask

  // Bus answers against the oldest expectation
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      cmpBus({s_axi_bresp, 32'h0}, expQ.pop_front());
    end
    if (s_axi_rvalid && s_axi_rready) begin
      cmpBus({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
    end
  end

  initial begin
    int i, k;
    for (i = 0; i < 4; i++) begin
      rst(2'h0);
      cmp(downstreamEq, {g[0], g[1]});
      cmp(upstreamEq, {g[2], g[3]});
      cmp(routeSel, rdm_pkg::RDM_ROUTE_LANE1);
      cmp(eqEnable, 1'b1);
      straps <= ~straps;
      tick(3);
      cmp(downstreamEq, {g[0], g[1]});
    end
    axr(rdm_pkg::CTRL_OFFSET, {rdm_pkg::RESP_OKAY, 32'h1});
    tick(1260);
    cmp(strapPullEn, 1'b0);
    slow <= 1'(xs());
    reqOn <= 1'b1;
    tick(3);
    reqOn <= 1'b0;
    tick(DB + 6);
    cmp(powerDown, 1'b0);
    reqOn <= 1'b1;
    tick(DB + 6);
    cmp(routeSel, rdm_pkg::RDM_ROUTE_LANE1);
    for (k = 0; k < 3 * RXD && !rxDetectReq; k++) tick(1);
    cmp(rxDetectReq, 1'b1);
    phy <= 4'b1100;
    tick(3);
    cmp(linkState, rdm_pkg::RDM_U0);
    cmp(rxTermEn, 1'b1);
    phy <= 4'b1101;
    tick(3);
    cmp(eqEnable, 1'b0);
    phy <= 4'b1110;
    tick(3);
    cmp(linkState, rdm_pkg::RDM_U1);
    cmp(eqEnable, 1'b1);
    phy <= 4'b1100;
    tick(3);
    cmp(linkState, rdm_pkg::RDM_U0);
    phy <= 4'b1110;
    tick(1256);
    cmp(linkState, rdm_pkg::RDM_U23);
    for (k = 0; k < 3 * RXD && !rxDetectReq; k++) tick(1);
    cmp(rxDetectReq, 1'b1);
    phy <= 4'b1101;
    tick(3);
    cmp(linkState, rdm_pkg::RDM_U0);
    phy <= 4'b1110;
    tick(1256);
    phy <= 4'b0110;
    tick(3);
    cmp(linkState, rdm_pkg::RDM_DISC);
    phy <= 4'b1100;
    tick(3);
    cmp(linkState, rdm_pkg::RDM_U0);
    reqFlip <= 1'b1;
    tick(DB + 6);
    cmp(routeSel, rdm_pkg::RDM_ROUTE_LANE2);
    reqOn <= 1'b0;
    tick(DB + 6);
    cmp(powerDown, 1'b1);
    cmp(routeSel, rdm_pkg::RDM_ROUTE_NONE);
    rst(2'(1 + xs() % 3));
    for (k = 0; k < 8; k++) begin
      axw(rdm_pkg::CTRL_OFFSET, k, rdm_pkg::RESP_OKAY);
      tick(3);
      cmp(routeSel, k[1:0] != 2'h1 ? rdm_pkg::RDM_ROUTE_NONE :
        (k[2] ? rdm_pkg::RDM_ROUTE_LANE2 : rdm_pkg::RDM_ROUTE_LANE1));
    end
    axw(rdm_pkg::CTRL_OFFSET, 32'h5, rdm_pkg::RESP_OKAY);
    axw(rdm_pkg::LANE2_GAIN_OFFSET, 32'hffff_fffb, rdm_pkg::RESP_OKAY);
    axw(rdm_pkg::HOST_GAIN_OFFSET, 32'h6, rdm_pkg::RESP_OKAY);
    axw(rdm_pkg::LANE1_GAIN_OFFSET, 32'h3, rdm_pkg::RESP_OKAY);
    tick(3);
    cmp(downstreamEq, 4'hb);
    cmp(upstreamEq, 4'h6);
    s_axi_wstrb <= 4'he;
    axw(rdm_pkg::LANE2_GAIN_OFFSET, 32'h1, rdm_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axr(rdm_pkg::LANE2_GAIN_OFFSET, {rdm_pkg::RESP_OKAY, 32'hb});
    axr(rdm_pkg::LANE1_GAIN_OFFSET, {rdm_pkg::RESP_OKAY, 32'h3});
    axr(rdm_pkg::STATUS_OFFSET, {rdm_pkg::RESP_OKAY, 32'h6bb9});
    axw(8'h14, 32'h1, rdm_pkg::RESP_SLVERR);
    axr(8'h14, {rdm_pkg::RESP_SLVERR, 32'h0});
    tick(2);
    test_done();
  end
endmodule // rdm_mode_ctrl_test
